// >>> dlic_pkg.sv
package dlic_pkg;

    // ------------------------------------------------------------------
    // Register map, word offsets on the Avalon-MM slave (byte address).
    // ------------------------------------------------------------------
    localparam logic [4:0] OFF_MASK_FIRST    = 5'h00;
    localparam logic [4:0] OFF_STATUS_FIRST  = 5'h04;
    localparam logic [4:0] OFF_MASK_SECOND   = 5'h08;
    localparam logic [4:0] OFF_STATUS_SECOND = 5'h0c;
    localparam logic [4:0] OFF_MASK_THIRD    = 5'h10;
    localparam logic [4:0] OFF_STATUS_THIRD  = 5'h14;
    localparam logic [4:0] OFF_CONTROL       = 5'h18;

    // ------------------------------------------------------------------
    // Widths, field positions and reset values.
    // ------------------------------------------------------------------
    localparam int          REG_W        = 16;
    localparam logic [15:0] MASK_RST     = 16'h0000;
    localparam logic [15:0] FIRST_FIQ    = 16'h000f;
    localparam logic [15:0] FIRST_IRQ    = 16'hfff0;
    localparam logic [15:0] SECOND_IRQ   = 16'h3007;
    localparam logic [15:0] THIRD_FIQ    = 16'h0001;
    localparam int          BIT_EXT_FAST = 0;
    localparam int          BIT_MEDIA    = 3;
    localparam int          BIT_EXT_ONE  = 5;
    localparam int          BIT_EXT_TWO  = 6;
    localparam int          BIT_EXT_THR  = 7;
    localparam int          BIT_SSI_DONE = 15;
    localparam int          BIT_KEY      = 0;
    localparam int          CTRL_IDLE    = 0;
    localparam int          NUM_SOURCES  = 22;

    // ------------------------------------------------------------------
    // Timing: deglitch tick period and idle clock restart delay.
    // ------------------------------------------------------------------
    localparam int CLK_MHZ           = 200;
    localparam int DEGLITCH_HZ       = 16384;
    localparam int DEGLITCH_CYCLES   = (CLK_MHZ * 1000000) / DEGLITCH_HZ;
    localparam int WAKE_CLOCKS       = 2;

endpackage

// >>> dlic_if.sv
`timescale 1ns/1ps
interface dlic_if;
    logic fast_req_n;
    logic norm_req_n;
    logic idle;
    logic cpu_clk_en;

    modport ctrl
    (
        output fast_req_n,
        output norm_req_n,
        input  idle,
        output cpu_clk_en
    );

    modport core
    (
        input  fast_req_n,
        input  norm_req_n,
        output idle,
        input  cpu_clk_en
    );
endinterface

// >>> dlic_ctrl.sv
// Chosen here: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
module dlic_ctrl
#(
    parameter int DEGLITCH_CYCLES = dlic_pkg::DEGLITCH_CYCLES
)
(
    input  wire logic        core_clk_i,
    input  wire logic        rst_i,
    dlic_if.ctrl             core_if,
    input  wire logic [4:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    input  wire logic        external_fast_pin_n_i,
    input  wire logic        battery_low_source_i,
    input  wire logic        watchdog_expired_source_i,
    input  wire logic        media_changed_source_i,
    input  wire logic        codec_sound_source_i,
    input  wire logic        external_pin_one_n_i,
    input  wire logic        external_pin_two_n_i,
    input  wire logic        external_source_three_i,
    input  wire logic        timer_one_underflow_i,
    input  wire logic        timer_two_underflow_i,
    input  wire logic        rtc_match_source_i,
    input  wire logic        periodic_tick_source_i,
    input  wire logic        serial_one_tx_empty_i,
    input  wire logic        serial_one_rx_full_i,
    input  wire logic        modem_status_change_i,
    input  wire logic        sync_serial_one_done_i,
    input  wire logic        key_press_source_i,
    input  wire logic        sync_serial_two_rx_i,
    input  wire logic        sync_serial_two_tx_i,
    input  wire logic        serial_two_tx_empty_i,
    input  wire logic        serial_two_rx_full_i,
    input  wire logic        codec_port_source_i
);

    // ------------------------------------------------------------------
    // Pin synchronisers.
    // ------------------------------------------------------------------
    localparam int NPIN = 5;
    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] pin_meta_ff;
    logic [NPIN-1:0] pin_sync_ff;

    // Pins are active low except the third external input and the media change input.
    assign pin_raw = {media_changed_source_i, external_source_three_i, ~external_pin_two_n_i,
                      ~external_pin_one_n_i, ~external_fast_pin_n_i};

    // Two flops per pin; only the second stage is read by logic.
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
            {pin_sync_ff, pin_meta_ff} <= '0;
        else
            {pin_sync_ff, pin_meta_ff} <= {pin_meta_ff, pin_raw};
    end

    // ------------------------------------------------------------------
    // Deglitcher for the media change input.
    // ------------------------------------------------------------------
    logic [15:0] tick_cnt_ff;
    logic        tick;
    logic        media_dg_ff;

    assign tick = (tick_cnt_ff == 16'(DEGLITCH_CYCLES - 1));

    // Free-running divider that models the slow sampling clock.
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
            tick_cnt_ff <= 16'h0000;
        else
            tick_cnt_ff <= tick ? 16'h0000 : tick_cnt_ff + 16'h0001;
    end

    // Resampling on the slow tick delays at most one tick period.
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
            media_dg_ff <= 1'b0;
        else if (tick)
            media_dg_ff <= pin_sync_ff[4];
    end

    // ------------------------------------------------------------------
    // Source assembly and end-of-transfer latch.
    // ------------------------------------------------------------------
    logic        ssi_latch_ff;
    logic        ssi_clear;
    logic [15:0] src_first;
    logic [15:0] src_second;
    logic [15:0] src_third;

    // Latch is set by the pulse and cleared by writing one to its status bit.
    assign ssi_clear = avs_write_i && avs_address_i == dlic_pkg::OFF_STATUS_FIRST &&
                       avs_byteenable_i[1] && avs_writedata_i[dlic_pkg::BIT_SSI_DONE];

    // The pulse sets the latch and wins over a clear in the same cycle.
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
            ssi_latch_ff <= 1'b0;
        else if (sync_serial_one_done_i)
            ssi_latch_ff <= 1'b1;
        else if (ssi_clear)
            ssi_latch_ff <= 1'b0;
    end

    // Level sources pass straight through; no per-source clear exists.
    assign src_first = {ssi_latch_ff, modem_status_change_i, serial_one_rx_full_i,
                        serial_one_tx_empty_i, periodic_tick_source_i, rtc_match_source_i,
                        timer_two_underflow_i, timer_one_underflow_i,
                        pin_sync_ff[3], pin_sync_ff[2], pin_sync_ff[1], codec_sound_source_i,
                        media_dg_ff, watchdog_expired_source_i, battery_low_source_i,
                        pin_sync_ff[0]};
    assign src_second = {2'b00, serial_two_rx_full_i, serial_two_tx_empty_i, 9'h000,
                         sync_serial_two_tx_i, sync_serial_two_rx_i, key_press_source_i};
    assign src_third = {15'h0000, codec_port_source_i};

    // ------------------------------------------------------------------
    // Mask registers and idle control.
    // ------------------------------------------------------------------
    logic [15:0] mask_first_ff;
    logic [15:0] mask_second_ff;
    logic [15:0] mask_third_ff;
    logic        idle_ff;
    logic        wr_lo;
    logic        wr_hi;

    assign wr_lo = avs_write_i && avs_byteenable_i[0];
    assign wr_hi = avs_write_i && avs_byteenable_i[1];

    // Masks start closed so nothing fires before software opens them.
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
            {mask_first_ff, mask_second_ff, mask_third_ff} <= {3{dlic_pkg::MASK_RST}};
        else
        begin
            if (avs_address_i == dlic_pkg::OFF_MASK_FIRST)
            begin
                if (wr_lo) mask_first_ff[7:0]  <= avs_writedata_i[7:0];
                if (wr_hi) mask_first_ff[15:8] <= avs_writedata_i[15:8];
            end
            if (avs_address_i == dlic_pkg::OFF_MASK_SECOND)
            begin
                if (wr_lo) mask_second_ff[7:0]  <= avs_writedata_i[7:0] & dlic_pkg::SECOND_IRQ[7:0];
                if (wr_hi) mask_second_ff[15:8] <= avs_writedata_i[15:8] & dlic_pkg::SECOND_IRQ[15:8];
            end
            if (avs_address_i == dlic_pkg::OFF_MASK_THIRD && wr_lo)
                mask_third_ff <= {15'h0000, avs_writedata_i[0]};
        end
    end

    // ------------------------------------------------------------------
    // Request combination and clock restart.
    // ------------------------------------------------------------------
    logic       fast_any;
    logic       norm_any;
    logic       any_req;
    logic       fast_req_ff;
    logic       norm_req_ff;
    logic [1:0] wake_cnt_ff;
    logic       clk_en_ff;

    // Plain OR in each group: no priority between members.
    assign fast_any = |((src_first & mask_first_ff & dlic_pkg::FIRST_FIQ) |
                        (src_third & mask_third_ff & dlic_pkg::THIRD_FIQ));
    assign norm_any = |((src_first & mask_first_ff & dlic_pkg::FIRST_IRQ) |
                        (src_second & mask_second_ff & dlic_pkg::SECOND_IRQ));
    assign any_req  = fast_any | norm_any;

    // Idle is entered by software or the core and ended by any unmasked request.
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
            idle_ff <= 1'b0;
        else if (idle_ff && any_req)
            idle_ff <= 1'b0;
        else if (core_if.idle || (avs_address_i == dlic_pkg::OFF_CONTROL && wr_lo &&
                                  avs_writedata_i[dlic_pkg::CTRL_IDLE]))
            idle_ff <= 1'b1;
    end

    // Registered, active-low; the core ranks fast above normal.
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
            {fast_req_ff, norm_req_ff} <= 2'b00;
        else
            {fast_req_ff, norm_req_ff} <= {fast_any, norm_any};
    end

    assign core_if.fast_req_n = ~fast_req_ff;
    assign core_if.norm_req_n = ~norm_req_ff;

    // Clock gate reopens two cycles after a request appears in idle.
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
            {wake_cnt_ff, clk_en_ff} <= 3'b001;
        else if (!idle_ff)
            {wake_cnt_ff, clk_en_ff} <= 3'b001;
        else if (any_req)
        begin
            wake_cnt_ff <= wake_cnt_ff + 2'b01;
            clk_en_ff   <= (wake_cnt_ff == 2'(dlic_pkg::WAKE_CLOCKS - 1));
        end
        else
            clk_en_ff <= 1'b0;
    end

    assign core_if.cpu_clk_en = clk_en_ff;

    // ------------------------------------------------------------------
    // Avalon-MM slave: writes take no wait state, reads take one.
    // ------------------------------------------------------------------
    logic rd_ack_ff;
    // The extra read cycle lets read data come from a flop yet stand at the accepting edge.
    assign avs_waitrequest_o = avs_read_i && !rd_ack_ff;

    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
            rd_ack_ff <= 1'b0;
        else
            rd_ack_ff <= avs_read_i && !rd_ack_ff;
    end

    // Status shows live sources; unused and unmapped bits read zero.
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
            avs_readdata_o <= 32'h00000000;
        else if (avs_read_i && !rd_ack_ff)
        begin
            case (avs_address_i)
                dlic_pkg::OFF_MASK_FIRST:    avs_readdata_o <= {16'h0000, mask_first_ff};
                dlic_pkg::OFF_STATUS_FIRST:  avs_readdata_o <= {16'h0000, src_first};
                dlic_pkg::OFF_MASK_SECOND:   avs_readdata_o <= {16'h0000, mask_second_ff};
                dlic_pkg::OFF_STATUS_SECOND: avs_readdata_o <= {16'h0000, src_second};
                dlic_pkg::OFF_MASK_THIRD:    avs_readdata_o <= {16'h0000, mask_third_ff};
                dlic_pkg::OFF_STATUS_THIRD:  avs_readdata_o <= {16'h0000, src_third};
                dlic_pkg::OFF_CONTROL:       avs_readdata_o <= {31'h00000000, idle_ff};
                default:                     avs_readdata_o <= 32'h00000000;
            endcase
        end
    end

endmodule

// >>> dlic_core.sv
`timescale 1ns/1ps
module dlic_core
(
    input  wire logic core_clk_i,
    input  wire logic rst_i,
    dlic_if.core      core_if,
    input  wire logic idle_req_i,
    output logic      fast_take_o,
    output logic      norm_take_o,
    output logic      clk_run_o
);

    // ------------------------------------------------------------------
    // Request sampling with two-stage synchronisation.
    // ------------------------------------------------------------------
    logic [1:0] meta_ff;
    logic [1:0] sync_ff;
    logic       idle_ff;

    // The requests are sampled through two flops before use.
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            meta_ff <= 2'b00;
            sync_ff <= 2'b00;
        end
        else
        begin
            meta_ff <= {~core_if.fast_req_n, ~core_if.norm_req_n};
            sync_ff <= meta_ff;
        end
    end

    // Fast wins over normal when both are pending.
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            fast_take_o <= 1'b0;
            norm_take_o <= 1'b0;
        end
        else
        begin
            fast_take_o <= sync_ff[1] && core_if.cpu_clk_en;
            norm_take_o <= sync_ff[0] && !sync_ff[1] && core_if.cpu_clk_en;
        end
    end

    // Idle request is registered and forwarded one cycle later, for as long as it is held.
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
            idle_ff <= 1'b0;
        else
            idle_ff <= idle_req_i;
    end

    assign core_if.idle = idle_ff;
    assign clk_run_o    = core_if.cpu_clk_en;

endmodule

// >>> dlic_ctrl_assertions.sv
`timescale 1ns/1ps
module dlic_ctrl_assertions
(
    input  wire logic core_clk_i,
    input  wire logic rst_i,
    input  wire logic fast_req_n,
    input  wire logic norm_req_n,
    input  wire logic idle,
    input  wire logic cpu_clk_en
);
    // ------------------------------------------------------------------
    // Wire checks between the two ends.
    // ------------------------------------------------------------------
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    // A stopped core clock must come back soon once any request stands.
    wake_fast_a: assert property ((!cpu_clk_en && !fast_req_n) |-> ##[1:3] cpu_clk_en)
        else $error("clock not restarted after fast request");
    wake_norm_a: assert property ((!cpu_clk_en && !norm_req_n) |-> ##[1:3] cpu_clk_en)
        else $error("clock not restarted after normal request");
    // Masks start cleared, so nothing may reach the core right after reset.
    reset_quiet_a: assert property ($fell(rst_i) |-> (fast_req_n && norm_req_n)[*2])
        else $error("request seen before any mask was set");
    reset_clock_a: assert property ($fell(rst_i) |-> cpu_clk_en)
        else $error("core clock stopped out of reset");
    // The core clock stays stopped while no request stands.
    clk_held_a: assert property ((!cpu_clk_en && fast_req_n && norm_req_n) |=> !cpu_clk_en)
        else $error("core clock restarted with no request");
    // A restart must follow a request that stood in the cycle before.
    wake_cause_a: assert property ($rose(cpu_clk_en) |-> (!$past(fast_req_n) || !$past(norm_req_n)))
        else $error("core clock restarted without a request");

    cover property ($rose(cpu_clk_en));
    cover property (!fast_req_n && !norm_req_n);
    cover property ($fell(fast_req_n));
    cover property ($fell(norm_req_n));
endmodule

// >>> dlic_ctrl_tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin miscompares++; $display("unexpected %s expected %h seen %h", nm, e, g); end end
module dlic_ctrl_tb;
    // ------------------------------------------------------------------
    // Bench signals.
    // ------------------------------------------------------------------
    logic        core_clk_i;
    logic        rst_i;
    logic [4:0]  address;
    logic        rd_en;
    logic        wr_en;
    logic [31:0] wdata;
    logic [3:0]  be;
    logic [31:0] rdata;
    logic        waitreq;
    logic [15:0] src [3];
    logic [15:0] map [3];
    logic        idle_req;
    logic        fast_take;
    logic        norm_take;
    logic        clk_run;
    logic [31:0] mon_e;
    logic [31:0] exp_q [$];
    logic [31:0] lfsr;
    logic [15:0] s0;
    logic [15:0] s1;
    logic [15:0] m0;
    logic [15:0] m1;
    logic        s2;
    logic        m2;
    logic        fe;
    logic        ne;
    int          miscompares;
    int          num_checks;

    dlic_if link();

    dlic_ctrl #(.DEGLITCH_CYCLES(8)) dlic_ctrl_inst (.core_clk_i(core_clk_i), .rst_i(rst_i), .core_if(link),
        .avs_address_i(address), .avs_read_i(rd_en), .avs_write_i(wr_en), .avs_writedata_i(wdata),
        .avs_byteenable_i(be), .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq),
        .external_fast_pin_n_i(~src[0][0]), .battery_low_source_i(src[0][1]),
        .watchdog_expired_source_i(src[0][2]), .media_changed_source_i(src[0][3]),
        .codec_sound_source_i(src[0][4]), .external_pin_one_n_i(~src[0][5]),
        .external_pin_two_n_i(~src[0][6]), .external_source_three_i(src[0][7]),
        .timer_one_underflow_i(src[0][8]), .timer_two_underflow_i(src[0][9]),
        .rtc_match_source_i(src[0][10]), .periodic_tick_source_i(src[0][11]),
        .serial_one_tx_empty_i(src[0][12]), .serial_one_rx_full_i(src[0][13]),
        .modem_status_change_i(src[0][14]), .sync_serial_one_done_i(src[0][15]),
        .key_press_source_i(src[1][0]), .sync_serial_two_rx_i(src[1][1]),
        .sync_serial_two_tx_i(src[1][2]), .serial_two_tx_empty_i(src[1][12]),
        .serial_two_rx_full_i(src[1][13]), .codec_port_source_i(src[2][0]));

    dlic_core dlic_core_inst (.core_clk_i(core_clk_i), .rst_i(rst_i), .core_if(link), .idle_req_i(idle_req),
        .fast_take_o(fast_take), .norm_take_o(norm_take), .clk_run_o(clk_run));

    dlic_ctrl_assertions dlic_ctrl_assertions_inst (.core_clk_i(core_clk_i), .rst_i(rst_i),
        .fast_req_n(link.fast_req_n), .norm_req_n(link.norm_req_n), .idle(link.idle),
        .cpu_clk_en(link.cpu_clk_en));

    // Clock at 200 MHz.
    initial
    begin
        core_clk_i = 1'b0;
        forever #2.5 core_clk_i = ~core_clk_i;
    end

    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    // ------------------------------------------------------------------
    // Tasks.
    // ------------------------------------------------------------------
    task automatic final_report();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk_i);
    endtask

    // One Avalon transfer; held until waitrequest is seen low at an edge.
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d, input logic [3:0] b);
        @(posedge core_clk_i);
        address <= a;
        wr_en   <= w;
        rd_en   <= !w;
        wdata   <= d;
        be      <= b;
        @(posedge core_clk_i);
        while (waitreq !== 1'b0) @(posedge core_clk_i);
        wr_en <= 1'b0;
        rd_en <= 1'b0;
    endtask

    task automatic rd(input logic [4:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h0, 4'hf);
    endtask

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 4'h3);
    endtask

    // Requests are looked at mid-cycle, after the edge updates have landed.
    task automatic chk_req(input logic ef, input logic en);
        @(negedge core_clk_i);
        `CHK("fast_req_n", ef, link.fast_req_n)
        `CHK("norm_req_n", en, link.norm_req_n)
    endtask

    // One source alone: status, mask gating, group, level or latch.
    task automatic sweep(input int p, input int b);
        logic       f;
        logic       lat;
        logic [4:0] mo;
        f   = (p == 2) || (p == 0 && b < 4);
        lat = (p == 0 && b == 15);
        mo  = 5'(p * 8);
        @(posedge core_clk_i);
        src[p] <= 16'h1 << b;
        cyc(24);
        rd(mo + 5'h4, 32'(16'h1 << b));
        chk_req(1'b1, 1'b1);
        wr(mo, 32'(16'h1 << b));
        cyc(4);
        chk_req(!f, f);
        @(posedge core_clk_i);
        src[p] <= 16'h0;
        cyc(24);
        chk_req(1'b1, !lat);
        if (lat)
        begin
            bus(1'b1, dlic_pkg::OFF_STATUS_FIRST, 32'h8000, 4'h2);
            cyc(4);
            chk_req(1'b1, 1'b1);
        end
        wr(mo, 32'h0);
    endtask

    // Read data are taken at the edge at which waitrequest is seen low.
    always @(posedge core_clk_i)
    begin
        if (rd_en && waitreq === 1'b0)
        begin
            mon_e = exp_q.pop_front();
            `CHK("readdata", mon_e, rdata)
        end
    end

    // The watchdog allows about twenty times the expected run length.
    initial
    begin
        cyc(40000);
        miscompares++;
        final_report();
    end

    // ------------------------------------------------------------------
    // Main sequence.
    // ------------------------------------------------------------------
    initial
    begin
        rst_i = 1'b1;
        address = 5'h0;
        rd_en = 1'b0;
        wr_en = 1'b0;
        wdata = 32'h0;
        be = 4'h0;
        src[0] = 16'h0;
        src[1] = 16'h0;
        src[2] = 16'h0;
        idle_req = 1'b0;
        lfsr = 32'hf559;
        miscompares = 0;
        num_checks = 0;
        map[0] = dlic_pkg::FIRST_FIQ | dlic_pkg::FIRST_IRQ;
        map[1] = dlic_pkg::SECOND_IRQ;
        map[2] = dlic_pkg::THIRD_FIQ;
        cyc(10);
        rst_i <= 1'b0;
        for (int a = 0; a < 6; a++) rd(5'(a * 4), 32'h0);
        rd(5'h1c, 32'h0);
        chk_req(1'b1, 1'b1);
        for (int p = 0; p < 3; p++)
        begin
            wr(5'(p * 8), 32'hffff);
            rd(5'(p * 8), {16'h0, map[p]});
            wr(5'(p * 8), 32'h0);
        end
        $display("test reset and masks done");
        for (int p = 0; p < 3; p++)
            for (int b = 0; b < 16; b++)
                if (map[p][b]) sweep(p, b);
        $display("test source map done");
        repeat (8)
        begin
            lfsr = lfsr_next(lfsr);
            m0 = lfsr[15:0];
            m1 = lfsr[31:16];
            lfsr = lfsr_next(lfsr);
            m2 = lfsr[7];
            s0 = lfsr[15:0] & 16'h7fff;
            s1 = lfsr[31:16] & dlic_pkg::SECOND_IRQ;
            s2 = lfsr[9];
            wr(dlic_pkg::OFF_MASK_FIRST, {16'h0, m0});
            wr(dlic_pkg::OFF_MASK_SECOND, {16'h0, m1});
            wr(dlic_pkg::OFF_MASK_THIRD, {31'h0, m2});
            @(posedge core_clk_i);
            src[0] <= s0;
            src[1] <= s1;
            src[2] <= {15'h0, s2};
            cyc(24);
            rd(dlic_pkg::OFF_STATUS_FIRST, {16'h0, s0});
            rd(dlic_pkg::OFF_STATUS_SECOND, {16'h0, s1});
            rd(dlic_pkg::OFF_STATUS_THIRD, {31'h0, s2});
            fe = |(s0 & m0 & dlic_pkg::FIRST_FIQ) | (s2 & m2);
            ne = |(s0 & m0 & dlic_pkg::FIRST_IRQ) | |(s1 & m1 & dlic_pkg::SECOND_IRQ);
            chk_req(!fe, !ne);
            `CHK("fast_take", fe, fast_take)
            `CHK("norm_take", ne && !fe, norm_take)
        end
        @(posedge core_clk_i);
        src[0] <= 16'h0;
        src[1] <= 16'h0;
        src[2] <= 16'h0;
        for (int p = 0; p < 3; p++) wr(5'(p * 8), 32'h0);
        $display("test random mix done");
        wr(dlic_pkg::OFF_CONTROL, 32'h1);
        cyc(6);
        @(negedge core_clk_i);
        `CHK("clk_run idle", 1'b0, clk_run)
        wr(dlic_pkg::OFF_MASK_FIRST, 32'h2);
        @(posedge core_clk_i);
        src[0] <= 16'h2;
        cyc(6);
        @(negedge core_clk_i);
        `CHK("clk_run wake", 1'b1, clk_run)
        wr(dlic_pkg::OFF_CONTROL, 32'h0);
        @(posedge core_clk_i);
        src[0] <= 16'h0;
        idle_req <= 1'b1;
        @(posedge core_clk_i);
        idle_req <= 1'b0;
        cyc(6);
        @(negedge core_clk_i);
        `CHK("clk_run core idle", 1'b0, clk_run)
        @(posedge core_clk_i);
        src[0] <= 16'h2;
        cyc(6);
        @(negedge core_clk_i);
        `CHK("clk_run core wake", 1'b1, clk_run)
        @(posedge core_clk_i);
        src[0] <= 16'h0;
        wr(dlic_pkg::OFF_MASK_FIRST, 32'h0);
        cyc(4);
        $display("test idle wake done");
        final_report();
    end
endmodule
